/* File: common/pcf_pkg.sv */
package pcf_pkg;
    // Predicate width: one bit per byte of a 256-bit vector.
    localparam int PRED_W = 32;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Element size codes.
    localparam logic [1:0] ESZ_1 = 2'h0;
    localparam logic [1:0] ESZ_2 = 2'h1;
    localparam logic [1:0] ESZ_4 = 2'h2;
    localparam logic [1:0] ESZ_8 = 2'h3;

    // Low-index masks that select the first bit of each element.
    localparam logic [2:0] EMASK_1 = 3'h0;
    localparam logic [2:0] EMASK_2 = 3'h1;
    localparam logic [2:0] EMASK_4 = 3'h3;
    localparam logic [2:0] EMASK_8 = 3'h7;

    // Register offsets and fields.
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam int CTRL_ALL_ACTIVE_BIT = 0;
    localparam logic CTRL_RESET = 1'h0;

    // Flag positions in the processor_state_flags vector.
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    // Reset state matches "no active element": lead 0, empty 1, not-last 1, ovf 0.
    localparam logic [3:0] FLAGS_RESET = 4'h6;

    typedef enum logic [1:0] {
        PCF_OP_TEST = 2'b00,
        PCF_OP_GEN = 2'b01,
        PCF_OP_COMPARE_TERMINATE = 2'b10
    } pcf_op_t;
endpackage

/* File: logic/pcf_flags.sv */
`timescale 1ns/1ns
module pcf_flags
    import pcf_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // Execution unit side
    input wire logic i_valid,
    input wire pcf_op_t i_op,
    input wire logic [1:0] i_esize,
    input wire logic i_unpredicated,
    input wire logic [PRED_W-1:0] i_pred,
    input wire logic [PRED_W-1:0] i_governing_predicate,
    input wire logic i_compare_terminate_lead,
    input wire logic i_compare_terminate_ovf,
    // Flags
    output logic o_flags_valid,
    output logic [3:0] o_processor_state_flags,
    // Condition evaluator
    output logic o_none_cond,
    output logic o_any_cond,
    output logic o_trailing_not_true_cond,
    output logic o_trailing_true_cond,
    output logic o_lead_true_cond,
    output logic o_lead_not_true_cond,
    output logic o_more_after_cond,
    output logic o_trailing_or_empty_cond,
    output logic o_ovf_set_cond,
    output logic o_ovf_clear_cond,
    output logic o_continue_cond,
    output logic o_terminate_cond
);
    logic ctrl_all_active_q;
    logic [3:0] flags_q;
    logic valid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [2:0] emask;
    logic [PRED_W-1:0] gov_eff;
    logic [PRED_W-1:0] start;
    logic [PRED_W-1:0] act;
    logic [PRED_W-1:0] first_hit;
    logic [PRED_W-1:0] last_hit;
    logic [PRED_W:0] below;
    logic [PRED_W:0] above;
    logic lead_c;
    logic empty_c;
    logic not_last_c;

    always_comb
    begin
        case (i_esize)
            ESZ_1: emask = EMASK_1;
            ESZ_2: emask = EMASK_2;
            ESZ_4: emask = EMASK_4;
            ESZ_8: emask = EMASK_8;
            default: emask = EMASK_1;
        endcase
    end

    // Unpredicated operations behave as if every governing bit were TRUE.
    assign gov_eff = (i_unpredicated || ctrl_all_active_q) ? '1 : i_governing_predicate;

    assign below[0] = 1'b0;
    assign above[PRED_W] = 1'b0;

    generate
        for (genvar gi = 0; gi < PRED_W; gi++)
        begin : g_bit
            localparam logic [2:0] LOW_IDX = 3'(gi);
            // Only the lowest bit of an element decides truth and activity.
            assign start[gi] = (LOW_IDX & emask) == 3'h0;
            assign act[gi] = start[gi] & gov_eff[gi];
            assign below[gi+1] = below[gi] | act[gi];
            assign above[gi] = above[gi+1] | act[gi];
            assign first_hit[gi] = act[gi] & ~below[gi];
            assign last_hit[gi] = act[gi] & ~above[gi+1];
        end
    endgenerate

    assign lead_c = |(first_hit & i_pred);
    assign empty_c = ~|(act & i_pred);
    assign not_last_c = ~|(last_hit & i_pred);

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            flags_q <= FLAGS_RESET;
        end
        else if (i_valid)
        begin
            case (i_op)
                PCF_OP_TEST, PCF_OP_GEN:
                begin
                    flags_q[FLAG_N] <= lead_c;
                    flags_q[FLAG_Z] <= empty_c;
                    flags_q[FLAG_C] <= not_last_c;
                    flags_q[FLAG_V] <= 1'b0;
                end
                PCF_OP_COMPARE_TERMINATE:
                begin
                    flags_q[FLAG_N] <= i_compare_terminate_lead;
                    flags_q[FLAG_V] <= i_compare_terminate_ovf;
                end
                default:
                begin
                    flags_q <= flags_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            valid_q <= 1'b0;
        end
        else
        begin
            valid_q <= i_valid && (i_op != 2'b11);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_all_active_q <= CTRL_RESET;
        end
        else if (i_wr && i_addr == REG_CTRL)
        begin
            ctrl_all_active_q <= i_wdata[CTRL_ALL_ACTIVE_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_q <= '0;
        end
        else if (i_rd && i_addr == REG_CTRL)
        begin
            rdata_q <= {{(DATA_W-1){1'b0}}, ctrl_all_active_q};
        end
        else if (i_rd && i_addr == REG_STATUS)
        begin
            rdata_q <= {{(DATA_W-4){1'b0}}, flags_q};
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign o_rdata = rdata_q;
    assign o_flags_valid = valid_q;
    assign o_processor_state_flags = flags_q;

    assign o_none_cond = flags_q[FLAG_Z];
    assign o_any_cond = ~flags_q[FLAG_Z];
    assign o_trailing_not_true_cond = flags_q[FLAG_C];
    assign o_trailing_true_cond = ~flags_q[FLAG_C];
    assign o_lead_true_cond = flags_q[FLAG_N];
    assign o_lead_not_true_cond = ~flags_q[FLAG_N];
    assign o_more_after_cond = flags_q[FLAG_C] & ~flags_q[FLAG_Z];
    assign o_trailing_or_empty_cond = ~flags_q[FLAG_C] | flags_q[FLAG_Z];
    assign o_ovf_set_cond = flags_q[FLAG_V];
    assign o_ovf_clear_cond = ~flags_q[FLAG_V];
    assign o_continue_cond = flags_q[FLAG_N] == flags_q[FLAG_V];
    assign o_terminate_cond = flags_q[FLAG_N] != flags_q[FLAG_V];

    logic flag_op;
    assign flag_op = i_valid && (i_op == PCF_OP_TEST || i_op == PCF_OP_GEN);

    property p_lead_elem0;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && gov_eff[0] && i_pred[0] |=> o_lead_true_cond;
    endproperty
    a_lead_elem0: assert property (p_lead_elem0) else $error("lead flag not set");

    property p_empty;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && ((i_pred & gov_eff & start) == '0) |=> o_none_cond && !o_any_cond;
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");

    property p_last_byte;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && i_esize == ESZ_8 && gov_eff[PRED_W-8] && i_pred[PRED_W-8]
        |=> !o_processor_state_flags[FLAG_C];
    endproperty
    a_last_byte: assert property (p_last_byte) else $error("not-last flag wrong");

    property p_ovf_clear;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op |=> o_ovf_clear_cond;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

    property p_no_active;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && gov_eff == '0 |=> o_trailing_not_true_cond && o_lead_not_true_cond;
    endproperty
    a_no_active: assert property (p_no_active) else $error("no-active flags wrong");

    property p_skip_inactive;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && i_esize == ESZ_2 && gov_eff == 32'h0000_0004 && i_pred == 32'h0000_0001
        |=> o_none_cond && !o_lead_true_cond;
    endproperty
    a_skip_inactive: assert property (p_skip_inactive) else $error("inactive element used");

    property p_odd_bit;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && i_esize == ESZ_2 && !i_unpredicated && !ctrl_all_active_q
        && i_governing_predicate == 32'h0000_0002 |=> o_none_cond;
    endproperty
    a_odd_bit: assert property (p_odd_bit) else $error("non-lead bit counted");

    property p_unpred;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && i_unpredicated && i_pred[0] |=> o_lead_true_cond;
    endproperty
    a_unpred: assert property (p_unpred) else $error("unpredicated lead wrong");

    property p_compare_terminate;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_valid && i_op == PCF_OP_COMPARE_TERMINATE
        |=> o_continue_cond == ($past(i_compare_terminate_lead) == $past(i_compare_terminate_ovf));
    endproperty
    a_compare_terminate: assert property (p_compare_terminate) else $error("continue condition wrong");

    property p_more_after;
        @(posedge i_clk_sys) disable iff (i_rst)
        flag_op && !empty_c && not_last_c |=> o_more_after_cond && !o_trailing_or_empty_cond;
    endproperty
    a_more_after: assert property (p_more_after) else $error("more-after wrong");

    c_compare_terminate_term: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        i_valid && i_op == PCF_OP_COMPARE_TERMINATE ##1 o_terminate_cond);
    c_more_after: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        flag_op ##1 o_more_after_cond);
    c_empty: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        flag_op && !i_unpredicated ##1 o_none_cond);
    c_esize8: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        flag_op && i_esize == ESZ_8 ##1 o_trailing_true_cond);
endmodule

/* File: tb/pcf_exec_model.sv */
`timescale 1ns/1ns
module pcf_exec_model
    import pcf_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Requests to the flag unit
    output logic o_valid,
    output pcf_op_t o_op,
    output logic [1:0] o_esize,
    output logic o_unpredicated,
    output logic [PRED_W-1:0] o_pred,
    output logic [PRED_W-1:0] o_gov,
    output logic o_compare_terminate_lead,
    output logic o_compare_terminate_ovf
);
    initial
    begin
        o_valid = 1'b0;
        o_op = PCF_OP_TEST;
        o_esize = 2'h0;
        o_unpredicated = 1'b0;
        o_pred = 32'h0;
        o_gov = 32'h0;
        o_compare_terminate_lead = 1'b0;
        o_compare_terminate_ovf = 1'b0;
    end

    // Waits for an edge, then presents one request and holds it until the next issue or idle call.
    task automatic issue(input logic [1:0] op, input logic [1:0] es, input logic un,
        input logic [31:0] p, input logic [31:0] g, input logic cl, input logic co);
        @(posedge i_clk_sys);
        o_valid <= 1'b1;
        o_op <= pcf_op_t'(op);
        o_esize <= es;
        o_unpredicated <= un;
        o_pred <= p;
        o_gov <= g;
        o_compare_terminate_lead <= cl;
        o_compare_terminate_ovf <= co;
    endtask

    // Between requests the predicate, governing and compare-terminate lead lines toggle so stale values are never relied on.
    task automatic idle();
        @(posedge i_clk_sys);
        o_valid <= 1'b0;
        o_pred <= ~o_pred;
        o_gov <= ~o_gov;
        o_compare_terminate_lead <= ~o_compare_terminate_lead;
    endtask
endmodule

/* File: tb/pcf_flags_tb.sv */
`timescale 1ns/1ns
module pcf_flags_tb;
    import pcf_pkg::*;
    typedef struct packed {
        logic [1:0] op;
        logic [1:0] es;
        logic un;
        logic [31:0] p;
        logic [31:0] g;
        logic cl;
        logic co;
        logic [3:0] f;
    } pcf_row_t;
    localparam int NROW = 12;
    localparam pcf_row_t ROWS [NROW] = '{
        '{2'h0, 2'h1, 1'b0, 32'h0000_0044, 32'h0000_00fc, 1'b0, 1'b0, 4'h8},
        '{2'h0, 2'h1, 1'b0, 32'h0000_1151, 32'h0000_0154, 1'b0, 1'b0, 4'h0},
        '{2'h0, 2'h0, 1'b0, 32'hffff_ffff, 32'h0000_0000, 1'b0, 1'b0, 4'h6},
        '{2'h1, 2'h3, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b0, 1'b0, 4'ha},
        '{2'h0, 2'h2, 1'b0, 32'heeee_eeee, 32'hffff_ffff, 1'b0, 1'b0, 4'h6},
        '{2'h1, 2'h0, 1'b0, 32'h8000_0000, 32'hffff_ffff, 1'b0, 1'b0, 4'h0},
        '{2'h2, 2'h0, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1, 1'b1, 4'h9},
        '{2'h2, 2'h0, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b1, 4'h1},
        '{2'h0, 2'h0, 1'b0, 32'h0000_0001, 32'h0000_0001, 1'b0, 1'b0, 4'h8},
        '{2'h0, 2'h1, 1'b0, 32'h0000_0001, 32'h0000_0004, 1'b0, 1'b0, 4'h6},
        '{2'h0, 2'h1, 1'b0, 32'hffff_ffff, 32'h0000_0002, 1'b0, 1'b0, 4'h6},
        '{2'h0, 2'h3, 1'b0, 32'h0100_0001, 32'h0101_0101, 1'b0, 1'b0, 4'h8}
    };
    logic i_clk_sys;
    logic i_rst;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [DATA_W-1:0] o_rdata;
    logic valid, unpred, c_lead, c_ovf, o_flags_valid;
    pcf_op_t op;
    logic [1:0] esize;
    logic [PRED_W-1:0] pred, gov;
    logic [3:0] o_processor_state_flags;
    wire logic [11:0] cond;
    int fail_count = 0;
    int checked = 0;

    pcf_exec_model u_exec (.i_clk_sys(i_clk_sys), .o_valid(valid), .o_op(op),
        .o_esize(esize), .o_unpredicated(unpred), .o_pred(pred), .o_gov(gov),
        .o_compare_terminate_lead(c_lead), .o_compare_terminate_ovf(c_ovf));
    pcf_flags dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_valid(valid), .i_op(op),
        .i_esize(esize), .i_unpredicated(unpred), .i_pred(pred),
        .i_governing_predicate(gov), .i_compare_terminate_lead(c_lead), .i_compare_terminate_ovf(c_ovf),
        .o_flags_valid(o_flags_valid), .o_processor_state_flags(o_processor_state_flags),
        .o_none_cond(cond[11]), .o_any_cond(cond[10]), .o_trailing_not_true_cond(cond[9]),
        .o_trailing_true_cond(cond[8]), .o_lead_true_cond(cond[7]),
        .o_lead_not_true_cond(cond[6]), .o_more_after_cond(cond[5]),
        .o_trailing_or_empty_cond(cond[4]), .o_ovf_set_cond(cond[3]),
        .o_ovf_clear_cond(cond[2]), .o_continue_cond(cond[1]), .o_terminate_cond(cond[0]));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Condition outputs expected from a flag value {lead, empty, not-last, overflow}.
    function automatic logic [11:0] conds(input logic [3:0] f);
        return {f[2], !f[2], f[1], !f[1], f[3], !f[3], f[1] & !f[2], !f[1] | f[2],
            f[0], !f[0], f[3] == f[0], f[3] != f[0]};
    endfunction

    task automatic expect_flags(input logic [3:0] f, input logic v);
        check({31'h0, o_flags_valid}, {31'h0, v});
        check({28'h0, o_processor_state_flags}, {28'h0, f});
        check({20'h0, cond}, {20'h0, conds(f)});
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, e);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    initial
    begin
        repeat (3000) @(posedge i_clk_sys);
        fail_count++;
        conclude();
    end

    initial
    begin
        i_rst = 1'b1;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1;
        expect_flags(4'h6, 1'b0);
        reg_rd(REG_CTRL, 32'h0);
        // Back-to-back requests; each row is checked while the next one is presented.
        for (int i = 0; i <= NROW; i++)
        begin
            if (i < NROW)
                u_exec.issue(ROWS[i].op, ROWS[i].es, ROWS[i].un, ROWS[i].p, ROWS[i].g,
                    ROWS[i].cl, ROWS[i].co);
            else
                u_exec.idle();
            #1;
            if (i > 0)
                expect_flags(ROWS[i-1].f, 1'b1);
        end
        // The unused operation code must leave the flags alone.
        u_exec.issue(2'h3, 2'h0, 1'b1, 32'hffff_ffff, 32'h0, 1'b0, 1'b1);
        u_exec.idle();
        #1;
        expect_flags(4'h8, 1'b0);
        reg_wr(REG_CTRL, 32'h1);
        u_exec.issue(2'h0, 2'h0, 1'b0, 32'h0000_0002, 32'h0, 1'b0, 1'b0);
        u_exec.idle();
        #1;
        expect_flags(4'h2, 1'b1);
        reg_rd(REG_STATUS, 32'h2);
        @(posedge i_clk_sys);
        #1;
        check(o_rdata, 32'h0);
        check({31'h0, o_flags_valid}, 32'h0);
        reg_rd(REG_CTRL, 32'h1);
        reg_rd(4'h8, 32'h0);
        reg_wr(REG_STATUS, 32'hf);
        reg_rd(REG_STATUS, 32'h2);
        reg_wr(4'hc, 32'hffff_ffff);
        reg_rd(4'hc, 32'h0);
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        @(posedge i_clk_sys);
        #1;
        expect_flags(4'h6, 1'b0);
        @(posedge i_clk_sys);
        i_rst <= 1'b0;
        reg_rd(REG_CTRL, 32'h0);
        conclude();
    end
endmodule
